/* File: sim/sdli_props.sv */
// checker: link properties watched beside the interface
`timescale 1ns/1ns
module sdli_props (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic sclk,
  input wire logic serial_data_in,
  input wire logic host_select_line,
  input wire logic host_load_line,
  input wire logic host_clear_line
);
  // ****************
  // rises seen while selected
  // ****************
  logic sclk_q_ff;
  logic [4:0] rise_cnt_ff;
  logic [4:0] nxt_rise_cnt;
  wire sclk_rise = sclk & ~sclk_q_ff;
  assign nxt_rise_cnt = host_select_line ? 5'h00 :
    rise_cnt_ff + {4'h0, sclk_rise};
  always_ff @(posedge clock) begin
    sclk_q_ff <= sys_rst | sclk;
    rise_cnt_ff <= sys_rst ? 5'h00 : nxt_rise_cnt;
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);
  // strobe low a few clocks, then back high
  sequence s_strobe(x);
    !x[*3] ##[1:2] x;
  endsequence
  chk_idle_clk_high: assert property (host_select_line |-> sclk)
    else $error("clock low while idle");
  chk_select_first: assert property ($fell(sclk) |-> !host_select_line)
    else $error("clock fell unselected");
  chk_data_steady: assert property
    ($rose(sclk) |-> $stable(serial_data_in))
    else $error("data moved at rise");
  chk_sixteen_rises: assert property
    ($rose(host_select_line) |-> rise_cnt_ff == 5'h10)
    else $error("bit count wrong");
  chk_clk_before_end: assert property
    ($rose(host_select_line) |-> sclk && $past(sclk))
    else $error("clock low at end");
  chk_load_when_idle: assert property
    (!host_load_line |-> host_select_line && sclk)
    else $error("load during shift");
  chk_load_pulse: assert property
    ($fell(host_load_line) |-> s_strobe(host_load_line))
    else $error("load pulse length");
  chk_clear_pulse: assert property
    ($fell(host_clear_line) |-> s_strobe(host_clear_line))
    else $error("clear pulse length");
endmodule : sdli_props

/* File: sim/serial_dac_load_interface_tb.sv */
// testbench: both ends joined; send, load and clear words
`timescale 1ns/1ns
module serial_dac_load_interface_tb;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic send_req = 1'b0;
  logic load_req = 1'b0;
  logic clear_req = 1'b0;
  logic [15:0] send_word = 16'h0000;
  logic [15:0] w;
  logic busy;
  logic shift_seen;
  logic [11:0] dac_code;
  logic [11:0] shadow = 12'h000;
  logic [11:0] held = 12'h000;
  logic [11:0] exp_q[$];
  int num_errors = 0;
  int tests_run = 0;
  event done_ev;
  always #10 clock = ~clock;
  sdli_if u_sdli_if ();
  sdli_host u_sdli_host (.clock(clock), .sys_rst(sys_rst),
    .link(u_sdli_if.host), .send_req(send_req), .send_word(send_word),
    .load_req(load_req), .clear_req(clear_req), .busy(busy));
  sdli_device u_sdli_device (.clock(clock), .sys_rst(sys_rst),
    .link(u_sdli_if.device), .dac_code(dac_code), .shift_seen(shift_seen));
  sdli_props u_sdli_props (.clock(clock), .sys_rst(sys_rst),
    .sclk(u_sdli_if.sclk), .serial_data_in(u_sdli_if.serial_data_in),
    .host_select_line(u_sdli_if.host_select_line),
    .host_load_line(u_sdli_if.host_load_line),
    .host_clear_line(u_sdli_if.host_clear_line));
  task automatic check(input logic [11:0] seen, input logic [11:0] want);
    tests_run++;
    if (seen !== want) begin
      num_errors++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, want);
    end
  endtask : check
  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : report_and_stop
  // 0 send, 1 load, 2 clear, 3 clear with load; wait idle plus sync lag
  task automatic op(input int k, input logic [15:0] v);
    @(posedge clock);
    send_req <= (k == 0);
    load_req <= (k == 1 || k == 3);
    clear_req <= (k >= 2);
    send_word <= v;
    @(posedge clock);
    send_req <= 1'b0;
    load_req <= 1'b0;
    clear_req <= 1'b0;
    repeat (200) begin
      @(negedge clock);
      if (busy === 1'b0) break;
    end
    // a host that never returns to idle is a mismatch
    if (busy !== 1'b0) num_errors++;
    repeat (8) @(posedge clock);
    if (k == 0) shadow = v[11:0];
    if (k == 1) held = shadow;
    if (k >= 2) held = 12'h000;
    exp_q.push_back(held);
    -> done_ev;
  endtask : op
  initial begin
    forever begin
      @(done_ev);
      // look off the edge so the output is settled
      @(negedge clock);
      check(dac_code, exp_q.pop_front());
    end
  end
  initial begin
    void'($urandom(93752));
    repeat (5) @(posedge clock);
    sys_rst <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      w = (i == 0) ? 16'hF555 : 16'($urandom);
      op(0, w);
      op(1, 16'h0000);
      op(0, 16'($urandom));
      op(1, 16'h0000);
      op(2 + i % 2, 16'h0000);
      $display("test %0d done", i);
    end
    // let the watcher take the last note before the verdict
    repeat (2) @(posedge clock);
    check({11'h000, shift_seen}, 12'h001);
    report_and_stop();
  end
  // whole run needs about 800 clocks
  initial begin
    #200000;
    num_errors++;
    report_and_stop();
  end
endmodule : serial_dac_load_interface_tb

/* File: src/sdli_device.sv */
// module: converter end, shift register and output register
//
// What this block does
// - host clock idles high, captures on rise
// - host lowers select before any bits
// - one bit captured each rising clock edge while selected
// - host sends bytes MSB first, eight edges
// - select stays low across both bytes
// - shift register keeps only last twelve bits
// - host raises select after second byte
// - clock already high before select rises
// - load strobe low copies shift to output
// - clear low forces zero code on the clock, after the two-stage synchroniser
`timescale 1ns/1ns
module sdli_device
  import sdli_pkg::*;
#(
  parameter int CODE_BITS = SDLI_CODE_BITS
) (
  input wire logic clock,
  input wire logic sys_rst,
  sdli_if.device link,
  output logic [CODE_BITS-1:0] dac_code,
  output logic shift_seen
);
  // ************************************************
  // checks
  // ************************************************
  // shift path needs at least two bits, the link carries sixteen
  if (CODE_BITS < 2 || CODE_BITS > 16) begin : g_bad_width
    $error("sdli_device: CODE_BITS out of range");
  end

  // ************************************************
  // pin synchronisers
  // ************************************************
  logic [1:0] sclk_sync_ff;
  logic [1:0] data_sync_ff;
  logic [1:0] sel_sync_ff;
  logic [1:0] load_sync_ff;
  logic [1:0] clear_sync_ff;
  logic sclk_prev_ff;
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      sclk_sync_ff <= 2'b11;
      data_sync_ff <= 2'b00;
      sel_sync_ff <= 2'b11;
      load_sync_ff <= 2'b11;
      clear_sync_ff <= 2'b11;
      sclk_prev_ff <= 1'b1;
    end else begin
      sclk_sync_ff <= {sclk_sync_ff[0], link.sclk};
      data_sync_ff <= {data_sync_ff[0], link.serial_data_in};
      sel_sync_ff <= {sel_sync_ff[0], link.host_select_line};
      load_sync_ff <= {load_sync_ff[0], link.host_load_line};
      clear_sync_ff <= {clear_sync_ff[0], link.host_clear_line};
      sclk_prev_ff <= sclk_sync_ff[1];
    end
  end

  // ************************************************
  // decoding
  // ************************************************
  wire sclk_rise = sclk_sync_ff[1] & ~sclk_prev_ff;
  wire selected = ~sel_sync_ff[1];
  // a rise while selected takes one bit; data delayed equally with clock
  wire take_bit = sclk_rise & selected;
  wire load_strobe_n = load_sync_ff[1];
  wire clear_now = ~clear_sync_ff[1];

  // ************************************************
  // shift and output registers
  // ************************************************
  logic [CODE_BITS-1:0] shift_ff;
  logic [CODE_BITS-1:0] code_ff;
  logic seen_ff;
  // older bits fall off the top, only the last twelve stay
  wire [CODE_BITS-1:0] nxt_shift =
    {shift_ff[CODE_BITS-2:0], data_sync_ff[1]};

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      shift_ff <= '0;
      seen_ff <= 1'b0;
    end else if (take_bit) begin
      shift_ff <= nxt_shift;
      seen_ff <= 1'b1;
    end
  end

  // clear takes priority over load; synchronised, so two clocks late
  always_ff @(posedge clock) begin
    if (sys_rst || clear_now) begin
      code_ff <= CODE_BITS'(SDLI_ZERO_CODE);
    end else if (!load_strobe_n) begin
      code_ff <= shift_ff;
    end
  end

  assign dac_code = code_ff;
  assign shift_seen = seen_ff;
endmodule : sdli_device

/* File: src/sdli_host.sv */
// module: host end, drives select, clock, data, load and clear
`timescale 1ns/1ns
module sdli_host
  import sdli_pkg::*;
#(
  parameter int DIV = SDLI_CLK_DIV
) (
  input wire logic clock,
  input wire logic sys_rst,
  sdli_if.host link,
  input wire logic send_req,
  input wire logic [15:0] send_word,
  input wire logic load_req,
  input wire logic clear_req,
  output logic busy
);
  // fall, rise and end check need three distinct counts in one period
  if (DIV < 4 || DIV > 255 || DIV % 2 != 0) begin : g_bad_div
    $error("sdli_host: DIV out of range");
  end

  // ************************************************
  // state
  // ************************************************
  typedef enum logic [3:0] {
    SDLI_IDLE = 4'b0001,
    SDLI_SHIFT = 4'b0010,
    SDLI_LOAD = 4'b0100,
    SDLI_CLEAR = 4'b1000
  } sdli_state_t;
  localparam int BITS = SDLI_BYTE_BITS * SDLI_BYTES;

  sdli_state_t state_ff;
  logic [7:0] div_ff;
  logic [4:0] bit_ff;
  logic [15:0] word_ff;
  logic sclk_ff;
  logic sel_ff;
  logic load_ff;
  logic clear_ff;
  logic sdo_ff;

  wire div_end = (div_ff == 8'(DIV - 1));
  wire last_bit = (bit_ff == 5'(BITS));
  wire idle = (state_ff == SDLI_IDLE);

  // ************************************************
  // sequencer
  // ************************************************
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      state_ff <= SDLI_IDLE;
      div_ff <= 8'h00;
      bit_ff <= 5'h00;
      word_ff <= SDLI_WORD_RST;
      sclk_ff <= 1'b1;
      sel_ff <= 1'b1;
      load_ff <= 1'b1;
      clear_ff <= 1'b1;
      sdo_ff <= 1'b0;
    end else begin
      div_ff <= (idle || div_end) ? 8'h00 : div_ff + 8'h01;
      case (state_ff)
        SDLI_IDLE: begin
          if (clear_req) begin
            clear_ff <= 1'b0;
            state_ff <= SDLI_CLEAR;
          end else if (load_req) begin
            load_ff <= 1'b0;
            state_ff <= SDLI_LOAD;
          end else if (send_req) begin
            // select falls a full sclk period before the first bit
            sel_ff <= 1'b0;
            word_ff <= send_word;
            bit_ff <= 5'h00;
            state_ff <= SDLI_SHIFT;
          end
        end
        SDLI_SHIFT: begin
          // data moves on the fall, so it stands through the next rise
          if (div_end) begin
            sclk_ff <= 1'b0;
            sdo_ff <= word_ff[15];
            word_ff <= {word_ff[14:0], 1'b0};
          end else if (div_ff == 8'(DIV / 2 - 1) && !sclk_ff) begin
            sclk_ff <= 1'b1;
            bit_ff <= bit_ff + 5'h01;
          end else if (div_ff == 8'(DIV - 2) && last_bit) begin
            // clock already high here, so select may rise safely
            sel_ff <= 1'b1;
            state_ff <= SDLI_IDLE;
          end
        end
        SDLI_LOAD: begin
          if (div_end) begin
            load_ff <= 1'b1;
            state_ff <= SDLI_IDLE;
          end
        end
        SDLI_CLEAR: begin
          if (div_end) begin
            clear_ff <= 1'b1;
            state_ff <= SDLI_IDLE;
          end
        end
        default: begin
          state_ff <= SDLI_IDLE;
        end
      endcase
    end
  end

  assign link.sclk = sclk_ff;
  assign link.serial_data_in = sdo_ff;
  assign link.host_select_line = sel_ff;
  assign link.host_load_line = load_ff;
  assign link.host_clear_line = clear_ff;
  assign busy = ~idle;
endmodule : sdli_host

/* File: src/sdli_if.sv */
// interface: the wires between host and converter
`timescale 1ns/1ns
interface sdli_if;
  logic sclk;
  logic serial_data_in;
  logic host_select_line;
  logic host_load_line;
  logic host_clear_line;
  modport host (
    output sclk,
    output serial_data_in,
    output host_select_line,
    output host_load_line,
    output host_clear_line
  );
  modport device (
    input sclk,
    input serial_data_in,
    input host_select_line,
    input host_load_line,
    input host_clear_line
  );
endinterface : sdli_if

/* File: src/sdli_pkg.sv */
// package: shared constants of the serial converter load link
package sdli_pkg;
  localparam int SDLI_BYTE_BITS = 8;
  localparam int SDLI_BYTES = 2;
  localparam int SDLI_CODE_BITS = 12;
  localparam int SDLI_CLK_DIV = 4;
  localparam logic [11:0] SDLI_ZERO_CODE = 12'h000;
  localparam logic [15:0] SDLI_WORD_RST = 16'h0000;
endpackage : sdli_pkg
